//--- rtl/qdl_pkg.sv
/*
  Shared constants and types of the quad converter serial-load control:
  serial word layout, register offsets and bit positions, reset values
  and the packed state of the control block.
  Assumes a single 100 MHz bus clock and a 32-bit AHB-Lite register bus.
*/
package qdl_pkg;

  // serial word
  localparam int             FRAME_BITS = 16;
  localparam logic [4:0]     FRAME_CNT  = 5'h10;
  localparam int             CODE_W     = 12;
  localparam int             NCH        = 4;
  localparam int             SEL_MSB    = 15;
  localparam int             SEL_LSB    = 14;
  localparam int             BUF_POS    = 13;

  // register byte offsets
  localparam logic [7:0]     OFF_CTRL   = 8'h00;
  localparam logic [7:0]     OFF_STATUS = 8'h04;
  localparam logic [7:0]     OFF_IN_A   = 8'h08;
  localparam logic [7:0]     OFF_OUT_A  = 8'h18;
  localparam logic [7:0]     OFF_LAST   = 8'h28;
  localparam logic [7:0]     OFF_ABORTS = 8'h2C;
  localparam logic [7:0]     OFF_STRIDE = 8'h04;

  // control register bits
  localparam int             CTRL_LOAD  = 0;
  localparam int             CTRL_CLEAR = 1;
  localparam int             CTRL_HOLD  = 2;

  // status register bits
  localparam int             ST_LINK    = 0;
  localparam int             ST_CHAIN   = 1;
  localparam int             ST_PDOWN   = 2;
  localparam int             ST_PEND    = 3;
  localparam int             ST_FULL    = 4;
  localparam int             ST_AVAIL   = 5;
  localparam int             ST_CNT_LSB = 8;

  typedef struct packed {
    logic              bufd;
    logic [CODE_W-1:0] code;
  } qdl_chan_t;

  typedef struct packed {
    logic                  valid;
    logic [FRAME_BITS-1:0] word;
  } qdl_word_t;

  typedef struct packed {
    logic [2:0]                 sclk_sy;
    logic [2:0]                 fs_sy;
    logic [1:0]                 din_sy;
    logic [1:0]                 clr_sy;
    logic [1:0]                 load_transfer_n_sy;
    logic [1:0]                 pd_sy;
    logic [1:0]                 chain_sy;
    logic                       link_en;
    logic [4:0]                 bit_cnt;
    logic [FRAME_BITS-1:0]      shift;
    qdl_word_t                  pend;
    logic                       sout;
    qdl_chan_t [NCH-1:0]        in_reg;
    qdl_chan_t [NCH-1:0]        dac_reg;
    logic [NCH-1:0]             drive_en;
    logic [1:0]                 ref_buf;
    logic                       hold;
    logic                       soft_ld;
    logic                       soft_clr;
    logic [FRAME_BITS-1:0]      last_word;
    logic [7:0]                 aborts;
    logic                       dp_wr;
    logic [7:0]                 dp_addr;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       resp;
  } qdl_state_t;

  // serial clock idles high, so no false edge follows reset
  localparam qdl_state_t QDL_ST_RST = '{
    sclk_sy: 3'h7,
    fs_sy:   3'h7,
    clr_sy:  2'h3,
    load_transfer_n_sy: 2'h3,
    pd_sy:   2'h3,
    ready:   1'b1,
    default: '0
  };

endpackage

//--- rtl/qdl_pair_buf.sv
/*
  Small valid/ready buffer, default two entries, between the serial
  capture and the word decoder of the serial-load control.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module qdl_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  // draining side
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int             PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int             CW   = $clog2(DEPTH + 1);
  localparam logic [CW-1:0]  FULL = CW'(DEPTH);
  localparam logic [PW-1:0]  LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } qdl_buf_st_t;

  qdl_buf_st_t q;
  qdl_buf_st_t n;
  logic        push;
  logic        pop;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == LAST) ? '0 : p + PW'(1);
  endfunction

  assign in_ready  = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp        = step(q.wp);
    end
    if (pop) begin
      n.rp = step(q.rp);
    end
    if (push && !pop) begin
      n.cnt = q.cnt + CW'(1);
    end else if (pop && !push) begin
      n.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule // qdl_pair_buf

//--- rtl/qdl_serial_load.sv
/*
  Digital control of a quad voltage-output converter: three-wire serial
  load with optional chain output, input and output code registers per
  channel, clear, load-transfer and power-down pins, and an AHB-Lite
  register view.
  Assumes serial pins and control pins are asynchronous to hclk and the
  serial clock is slow enough for hclk to see both of its levels.
*/
`timescale 1ns/1ns

// Summary of operation
// - clear input low zeroes every input and output code register.
// - load-transfer low copies each input register to its output register.
// - one load-transfer pulse updates all channels together.
// - buffer bit of each channel word picks buffered reference use.
// - chain enable level selects chained or standalone framing.
// - power-down low disables all four output drivers.
// - sixteen-bit shift register samples data on serial clock falls.
// - after a completed write the serial input is ignored.
// - frame-select falling re-arms the serial input for a new frame.
// - sixteen falling edges after frame-select fall carry the word; chained, the last sixteen before frame-select rises.
// - frame-select rising before sixteen bits aborts with no change.
// - serial output changes on serial clock rises.
// - serial output presents the shift register's outgoing bit.
// - channel codes are straight unsigned binary, twelve bits.
// - channels A,B share reference pair 0; C,D share pair 1.
module qdl_serial_load (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // serial link
  input  wire logic        frame_sel_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output      logic        serial_out,
  // control pins
  input  wire logic        clear_all_n,
  input  wire logic        load_transfer_n,
  input  wire logic        hw_powerdown_n,
  input  wire logic        chain_enable,
  // converter side
  output      logic [11:0] out_ch_a,
  output      logic [11:0] out_ch_b,
  output      logic [11:0] out_ch_c,
  output      logic [11:0] out_ch_d,
  output      logic [3:0]  out_drive_en,
  output      logic [3:0]  chan_buf_sel,
  output      logic        ref_in_pair0_buf_on,
  output      logic        ref_in_pair1_buf_on
);

  qdl_pkg::qdl_state_t                  q;
  qdl_pkg::qdl_state_t                  n;
  logic                                 buf_in_ready;
  logic                                 buf_out_valid;
  logic [qdl_pkg::FRAME_BITS-1:0]       buf_out_data;
  logic                                 buf_out_ready;
  logic                                 addr_phase;
  logic                                 word_size;
  logic                                 ctrl_wr;

  // a transfer is taken only while the bus itself is ready
  assign addr_phase = hsel & htrans[1] & hready;

  // only whole-word writes reach the control word; narrower ones are
  // answered okay and dropped, so a byte store cannot half-set it
  assign word_size  = (hsize == 3'h2);
  assign ctrl_wr    = q.dp_wr & (q.dp_addr == qdl_pkg::OFF_CTRL);

  // decoder stalls only when software freezes it
  assign buf_out_ready = ~q.hold;

  qdl_pair_buf #(
    .WIDTH (qdl_pkg::FRAME_BITS),
    .DEPTH (2)
  ) u_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (q.pend.valid),
    .in_data   (q.pend.word),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_out_ready)
  );

  // register read view, taken from next state so a write is seen at once
  function automatic logic [31:0] rd_word(
    input logic [7:0]          a,
    input qdl_pkg::qdl_state_t s,
    input logic                full,
    input logic                avail
  );
    logic [31:0] r;
    r = 32'h0;
    case (a)
      qdl_pkg::OFF_CTRL: begin
        r[qdl_pkg::CTRL_HOLD] = s.hold;
      end
      qdl_pkg::OFF_STATUS: begin
        r[qdl_pkg::ST_LINK]  = s.link_en;
        r[qdl_pkg::ST_CHAIN] = s.chain_sy[1];
        r[qdl_pkg::ST_PDOWN] = ~s.pd_sy[1];
        r[qdl_pkg::ST_PEND]  = s.pend.valid;
        r[qdl_pkg::ST_FULL]  = full;
        r[qdl_pkg::ST_AVAIL] = avail;
        r[qdl_pkg::ST_CNT_LSB +: 5] = s.bit_cnt;
      end
      qdl_pkg::OFF_LAST: begin
        r[qdl_pkg::FRAME_BITS-1:0] = s.last_word;
      end
      qdl_pkg::OFF_ABORTS: begin
        r[7:0] = s.aborts;
      end
      default: begin
        for (int i = 0; i < qdl_pkg::NCH; i++) begin
          if (a == qdl_pkg::OFF_IN_A + 8'(i * 4)) begin
            r[qdl_pkg::CODE_W:0] = s.in_reg[i];
          end
          if (a == qdl_pkg::OFF_OUT_A + 8'(i * 4)) begin
            r[qdl_pkg::CODE_W:0] = s.dac_reg[i];
          end
        end
      end
    endcase
    rd_word = r;
  endfunction

  always_comb begin
    logic                           sclk_fall;
    logic                           sclk_rise;
    logic                           fs_fall;
    logic                           fs_rise;
    logic                           fs_low;
    logic                           chain;
    logic                           do_push;
    logic [qdl_pkg::FRAME_BITS-1:0] push_word;
    logic [1:0]                     sel;
    logic                           take;
    sclk_fall = 1'b0;
    sclk_rise = 1'b0;
    fs_fall   = 1'b0;
    fs_rise   = 1'b0;
    fs_low    = 1'b0;
    chain     = 1'b0;
    do_push   = 1'b0;
    push_word = '0;
    sel       = 2'h0;
    take      = 1'b0;
    n = q;

    // pin synchronisers; stage 0 only feeds stage 1
    n.sclk_sy  = {q.sclk_sy[1:0], sclk};
    n.fs_sy    = {q.fs_sy[1:0], frame_sel_n};
    n.din_sy   = {q.din_sy[0], din};
    n.clr_sy   = {q.clr_sy[0], clear_all_n};
    n.load_transfer_n_sy  = {q.load_transfer_n_sy[0], load_transfer_n};
    n.pd_sy    = {q.pd_sy[0], hw_powerdown_n};
    n.chain_sy = {q.chain_sy[0], chain_enable};

    // sampling limit: each sclk level must last long enough for hclk to see it
    sclk_fall = q.sclk_sy[2] & ~q.sclk_sy[1];
    sclk_rise = ~q.sclk_sy[2] & q.sclk_sy[1];
    fs_fall   = q.fs_sy[2] & ~q.fs_sy[1];
    fs_rise   = ~q.fs_sy[2] & q.fs_sy[1];
    fs_low    = ~q.fs_sy[1];
    chain     = q.chain_sy[1];

    if (fs_fall) begin
      n.link_en = 1'b1;
      n.bit_cnt = 5'h00;
    end

    // input ignored unless armed by frame-select
    if (q.link_en && fs_low && sclk_fall) begin
      n.shift = {q.shift[qdl_pkg::FRAME_BITS-2:0], q.din_sy[1]};
      if (q.bit_cnt != qdl_pkg::FRAME_CNT) begin
        n.bit_cnt = q.bit_cnt + 5'h01;
      end
      if (!chain && n.bit_cnt == qdl_pkg::FRAME_CNT) begin
        do_push   = 1'b1;
        push_word = n.shift;
        n.link_en = 1'b0;
      end
    end

    if (fs_rise && n.link_en) begin
      if (chain && n.bit_cnt == qdl_pkg::FRAME_CNT) begin
        do_push   = 1'b1;
        push_word = n.shift;
      end else begin
        n.aborts = q.aborts + 8'h01;
      end
      n.link_en = 1'b0;
    end

    // outgoing bit moves on the rise, stable for the next fall
    if (sclk_rise) begin
      n.sout = q.shift[qdl_pkg::FRAME_BITS-1];
    end

    // word waiting for the buffer; a stalled buffer holds it here
    if (q.pend.valid && buf_in_ready) begin
      n.pend.valid = 1'b0;
    end
    if (do_push) begin
      n.pend.valid = 1'b1;
      n.pend.word  = push_word;
      n.last_word  = push_word;
    end

    // decode: address, reference buffer bit, unsigned code
    take = buf_out_valid & buf_out_ready;
    sel  = buf_out_data[qdl_pkg::SEL_MSB:qdl_pkg::SEL_LSB];
    if (take) begin
      n.in_reg[sel].bufd = buf_out_data[qdl_pkg::BUF_POS];
      n.in_reg[sel].code = buf_out_data[qdl_pkg::CODE_W-1:0];
    end

    // level-sensitive copy, so a held-low pin tracks every write; a
    // channel with no new word is copied onto itself, which is harmless
    for (int i = 0; i < qdl_pkg::NCH; i++) begin
      if (!q.load_transfer_n_sy[1] || q.soft_ld) begin
        n.dac_reg[i] = n.in_reg[i];
      end
    end

    // clear overrides any write or transfer in the same cycle
    if (!q.clr_sy[1] || q.soft_clr) begin
      n.in_reg  = '0;
      n.dac_reg = '0;
    end

    // codes are kept through power-down; only the drivers let go
    n.drive_en = q.pd_sy[1] ? 4'hF : 4'h0;

    // each reference pair buffers while either of its channels asks
    // for it; taken from the output registers so the reference mode
    // changes together with the codes on a transfer
    n.ref_buf[0] = n.dac_reg[0].bufd | n.dac_reg[1].bufd;
    n.ref_buf[1] = n.dac_reg[2].bufd | n.dac_reg[3].bufd;

    // bus defaults: never waits, never errs; strobes last one cycle
    n.ready    = 1'b1;
    n.resp     = 1'b0;
    n.soft_ld  = 1'b0;
    n.soft_clr = 1'b0;
    n.dp_wr    = 1'b0;

    // write data phase; only the control word takes data, the rest
    // of the map is read-only and a write there is simply dropped
    if (ctrl_wr) begin
      n.soft_ld  = hwdata[qdl_pkg::CTRL_LOAD];
      n.soft_clr = hwdata[qdl_pkg::CTRL_CLEAR];
      n.hold     = hwdata[qdl_pkg::CTRL_HOLD];
    end

    // address phase: no wait states, so read data is registered here
    // and stands through the whole data phase that follows; a write
    // in the data phase just ending is already in n and reads back
    if (addr_phase) begin
      n.dp_wr   = hwrite & word_size;
      n.dp_addr = haddr[7:0];
      if (!hwrite) begin
        n.rdata = rd_word(haddr[7:0], n, ~buf_in_ready, buf_out_valid);
      end
    end
  end

  // bus outputs
  assign hrdata              = q.rdata;
  assign hreadyout           = q.ready;
  assign hresp               = q.resp;

  // chain output, moved only on serial clock rises
  assign serial_out          = q.sout;

  // converter codes come from the output registers, never the input
  // registers, so nothing moves until a transfer or a clear
  assign out_ch_a            = q.dac_reg[0].code;
  assign out_ch_b            = q.dac_reg[1].code;
  assign out_ch_c            = q.dac_reg[2].code;
  assign out_ch_d            = q.dac_reg[3].code;

  // driver enables, low while powered down
  assign out_drive_en        = q.drive_en;

  // reference pair buffer controls
  assign ref_in_pair0_buf_on = q.ref_buf[0];
  assign ref_in_pair1_buf_on = q.ref_buf[1];

  // per-channel buffer choice follows the word last transferred
  for (genvar g = 0; g < qdl_pkg::NCH; g++) begin : g_bsel
    assign chan_buf_sel[g] = q.dac_reg[g].bufd;
  end

  // reset branch loads constants only; synchroniser stages start at
  // the idle level of their pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= qdl_pkg::QDL_ST_RST;
    end else begin
      q <= n;
    end
  end

endmodule // qdl_serial_load

//--- dv/qdl_serial_load_chk.sv
/*
  Port-level checker for the quad converter serial-load control.
  Assumes it is bound to qdl_serial_load and sees only its ports.
*/
`timescale 1ns/1ns
module qdl_serial_load_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // control pins
  input wire logic        clear_all_n,
  input wire logic        load_transfer_n,
  input wire logic        hw_powerdown_n,
  // converter side
  input wire logic [11:0] out_ch_a,
  input wire logic [11:0] out_ch_b,
  input wire logic [11:0] out_ch_c,
  input wire logic [11:0] out_ch_d,
  input wire logic [3:0]  out_drive_en,
  input wire logic [3:0]  chan_buf_sel,
  input wire logic        ref_in_pair0_buf_on,
  input wire logic        ref_in_pair1_buf_on
);
  // cycles with no clear, transfer or bus access, saturating; a bus
  // access may carry a software load, so it restarts the count
  logic [3:0] calm_q;
  logic [3:0] calm_d;

  always_comb begin
    calm_d = 4'h0;
    if (clear_all_n && load_transfer_n && !(hsel && htrans[1])) begin
      calm_d = (calm_q == 4'hF) ? calm_q : calm_q + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      calm_q <= 4'h0;
    end else begin
      calm_q <= calm_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_clr_zeroes_outs: assert property (
    !clear_all_n [*3] |-> ##[0:4]
    ({out_ch_a, out_ch_b, out_ch_c, out_ch_d} == 48'h0))
    else $error("clear left a code");
  // pin synchronisers delay a transfer, so wait out their depth
  a_outs_held: assert property (
    calm_q >= 4'h8 |=> $stable({out_ch_a, out_ch_b, out_ch_c, out_ch_d}))
    else $error("code moved without transfer");
  a_pd_drv_off: assert property (
    !hw_powerdown_n [*2] |-> ##[0:4] (out_drive_en == 4'h0))
    else $error("driver on in power-down");
  a_pd_drv_on: assert property (
    hw_powerdown_n [*4] |-> ##[0:4] (out_drive_en == 4'hF))
    else $error("driver off while powered");
  a_ref0_pair: assert property (
    $changed(chan_buf_sel) |-> ##[0:2]
    (ref_in_pair0_buf_on == (chan_buf_sel[0] | chan_buf_sel[1])))
    else $error("pair 0 buffer mismatch");
  a_ref1_pair: assert property (
    $changed(chan_buf_sel) |-> ##[0:2]
    (ref_in_pair1_buf_on == (chan_buf_sel[2] | chan_buf_sel[3])))
    else $error("pair 1 buffer mismatch");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_ready_bound: assert property (
    hsel && htrans[1] && hready |-> ##[0:16] hreadyout)
    else $error("bus wait too long");
endmodule // qdl_serial_load_chk

bind qdl_serial_load qdl_serial_load_chk i_qdl_serial_load_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .clear_all_n(clear_all_n), .load_transfer_n(load_transfer_n),
  .hw_powerdown_n(hw_powerdown_n), .out_ch_a(out_ch_a),
  .out_ch_b(out_ch_b), .out_ch_c(out_ch_c), .out_ch_d(out_ch_d),
  .out_drive_en(out_drive_en), .chan_buf_sel(chan_buf_sel),
  .ref_in_pair0_buf_on(ref_in_pair0_buf_on),
  .ref_in_pair1_buf_on(ref_in_pair1_buf_on));

//--- dv/qdl_host_mdl.sv
/*
  Host serial port model: frames words MSB first at an 80 ns bit period.
  Assumes the caller waits for each send to return before the next.
*/
`timescale 1ns/1ns
module qdl_host_mdl (
  // serial link toward the device
  output logic      frame_sel_n,
  output logic      sclk,
  output logic      din,
  // chained output from the device
  input  wire logic serial_out
);
  // clock idles high and stands still between frames
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end

  task automatic send(input logic [31:0] w, input int n,
                      output logic [31:0] rb);
    rb = 32'h0;
    #3 frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #20 din = w[i];
      #20 sclk = 1'b0;
      rb = {rb[30:0], serial_out};
      #40 sclk = 1'b1;
    end
    #40 frame_sel_n = 1'b1;
    // released line shows no stale bit
    din = ~din;
    #200;
  endtask
endmodule // qdl_host_mdl

//--- dv/qdl_serial_load_tb.sv
/*
  Self-checking bench of the serial-load control: bus reads and writes,
  serial frames from the host model, control pin sequences.
  Assumes a 100 MHz hclk and the checker bound beside the design.
*/
`timescale 1ns/1ns
module qdl_serial_load_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, rb;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        fs_n, sclk, din, sout, clr_n, load_transfer_n_n, pd_n, chain;
  logic [11:0] oa, ob, oc, od;
  logic [3:0]  drv, bsel;
  logic        ref0, ref1;
  int          mismatches, samples_checked;
  int          cyc = 0;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  qdl_serial_load i_qdl_serial_load (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .frame_sel_n(fs_n), .sclk(sclk), .din(din),
    .serial_out(sout), .clear_all_n(clr_n), .load_transfer_n(load_transfer_n_n),
    .hw_powerdown_n(pd_n), .chain_enable(chain), .out_ch_a(oa),
    .out_ch_b(ob), .out_ch_c(oc), .out_ch_d(od), .out_drive_en(drv),
    .chan_buf_sel(bsel), .ref_in_pair0_buf_on(ref0),
    .ref_in_pair1_buf_on(ref1));

  qdl_host_mdl i_qdl_host_mdl (
    .frame_sel_n(fs_n), .sclk(sclk), .din(din), .serial_out(sout));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // no done flag on the serial side: allow for pin synchronisers
  task automatic send(input logic [31:0] w, input int n);
    i_qdl_host_mdl.send(w, n, rb);
    repeat (12) @(posedge hclk);
  endtask

  task automatic pulse_load_transfer_n;
    @(posedge hclk);
    load_transfer_n_n <= 1'b0;
    repeat (4) @(posedge hclk);
    load_transfer_n_n <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict;
    end
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {clr_n, load_transfer_n_n, pd_n} = 3'b111;
    chain = 1'b0;
    {mismatches, samples_checked} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      send({i[1:0], i[0], 1'b0, 12'hFFF >> i}, 16);
    end
    chk(oa, 12'h000);
    pulse_load_transfer_n;
    chk({oa, ob, oc, od}, 48'hFFF7FF3FF1FF);
    chk(bsel, 4'b1010);
    chk({ref1, ref0}, 2'b11);
    send({4'h0, 12'h0F0}, 10);
    pulse_load_transfer_n;
    chk(oa, 12'hFFF);
    ahb(1'b0, qdl_pkg::OFF_ABORTS, 32'h0);
    chk(rd[7:0], 8'h01);
    load_transfer_n_n <= 1'b0;
    send({4'h4, 12'h5A5}, 16);
    chk(ob, 12'h5A5);
    chk({ref1, ref0}, 2'b10);
    chain <= 1'b1;
    ahb(1'b0, qdl_pkg::OFF_STATUS, 32'h0);
    chk(rd[qdl_pkg::ST_CHAIN], 1'b1);
    send(32'h8123CABC, 32);
    chk({oc, od}, 24'h3FFABC);
    chk(rb[15:0], 16'h8123);
    chain <= 1'b0;
    load_transfer_n_n <= 1'b1;
    // unmapped slot must simply be accepted
    ahb(1'b1, 8'h40, 32'h0000FFFF);
    // software load moves a word waiting in an input register
    send({4'h0, 12'h123}, 16);
    chk(oa, 12'hFFF);
    ahb(1'b1, qdl_pkg::OFF_CTRL, 32'h00000001);
    repeat (2) @(posedge hclk);
    chk(oa, 12'h123);
    pd_n <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(drv, 4'h0);
    pd_n <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(drv, 4'hF);
    clr_n <= 1'b0;
    repeat (4) @(posedge hclk);
    clr_n <= 1'b1;
    repeat (8) @(posedge hclk);
    chk({oa, ob, oc, od}, 48'h0);
    print_verdict;
  end
endmodule // qdl_serial_load_tb
